// ### src/sbsr_pkg.sv
// What this block does
// [RL1] controller writes an 8-bit enable mask, 0 to 255; a 1 enables that status bit
// [RL2] a zero mask bit blocks its status bit; an all-zero mask blocks every request
// [RL3] mask bit 6 ignores writes and always reads back zero
// [RL4] mask query returns the current mask as one unsigned byte
// [RL5] mask writes are applied in local and in remote state alike
// [RL6] status query returns bits 0-5 and 7 with master summary in bit 6
// [RL7] serial poll returns the status byte with the request flag in bit 6
// [RL8] master summary is 1 when any status bit enabled by the mask is 1
// [RL9] request flag is 1 when the device has issued a service request
// [RL10] bit 5 set while an enabled standard event is pending
// [RL11] bit 4 is 1 while the output queue holds at least one byte
// [RL12] bit 2 is set when a numeric argument was adapted to a legal value
// [RL13] bit 0 is set when an enabled internal state is entered
// [RL14] bits 7, 3 and 1 are reserved and read as zero
// [RL15] request line rises when summary rises; flag latched until polled
package sbsr_pkg;
    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int SBSR_BIT_INTERNAL = 0;
    localparam int SBSR_BIT_RSV_ONE  = 1;
    localparam int SBSR_BIT_ADAPTED  = 2;
    localparam int SBSR_BIT_RSV_THR  = 3;
    localparam int SBSR_BIT_MSG_AVL  = 4;
    localparam int SBSR_BIT_EVENT    = 5;
    localparam int SBSR_BIT_SUMMARY  = 6;
    localparam int SBSR_BIT_RSV_TOP  = 7;
    // bits that may ever be nonzero in the status source and in the mask
    localparam logic [7:0] SBSR_STATUS_LIVE = 8'h35;
    localparam logic [7:0] SBSR_MASK_WRITABLE = 8'hbf;
    localparam logic [7:0] SBSR_MASK_RESET = 8'h00;
endpackage : sbsr_pkg

// ### src/sbsr_summary.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// master summary: or of status bits gated by the mask
// ------------------------------------------------------------
module sbsr_summary
    import sbsr_pkg::*;
(
    input  wire logic [7:0] status_in,
    input  wire logic [7:0] mask_in,
    output logic            summary_out
);
    // bit 6 is excluded so the summary never feeds itself
    assign summary_out = |(status_in & mask_in & SBSR_STATUS_LIVE); // [RL8] [RL2]
endmodule // sbsr_summary

// ### src/sbsr_mask_reg.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// service request enable mask
// ------------------------------------------------------------
module sbsr_mask_reg
    import sbsr_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] mask_out
);
    typedef struct packed {
        logic [7:0] mask;
    } sbsr_mask_st_t;

    sbsr_mask_st_t st_r;
    sbsr_mask_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // no local/remote gating on purpose
        if (wr_in) begin // [RL5] [RL1]
            st_nxt.mask = wdata_in & SBSR_MASK_WRITABLE; // [RL3]
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            st_r.mask <= SBSR_MASK_RESET;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign mask_out = st_r.mask; // [RL4]
endmodule // sbsr_mask_reg

// ### src/sbsr_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// status byte and service request top
// ------------------------------------------------------------
module sbsr_top
    import sbsr_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    // summary sources from the surrounding instrument
    input  wire logic       event_summary_in,
    input  wire logic       queue_not_empty_in,
    input  wire logic       value_adapted_flag_in,
    input  wire logic       internal_change_flag_in,
    // controller requests, one-cycle pulses
    input  wire logic       mask_wr_in,
    input  wire logic [7:0] mask_wdata_in,
    input  wire logic       mask_rd_in,
    input  wire logic       status_rd_in,
    input  wire logic       poll_in,
    // answers
    output logic      [7:0] rdata_out,
    output logic            rvalid_out,
    output logic            srq_out,
    output logic            summary_out
);
    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
        logic       rqs;
        logic       summ_q;
    } sbsr_st_t;

    sbsr_st_t   st_r;
    sbsr_st_t   st_nxt;
    logic [7:0] mask;
    logic [7:0] status;
    logic       summary;

    // ------------------------------------------------------------
    // status byte assembly, reserved bits tied low
    // ------------------------------------------------------------
    always_comb begin
        status = 8'h00; // [RL14]
        status[SBSR_BIT_EVENT]    = event_summary_in;        // [RL10]
        status[SBSR_BIT_MSG_AVL]  = queue_not_empty_in;      // [RL11]
        status[SBSR_BIT_ADAPTED]  = value_adapted_flag_in;   // [RL12]
        status[SBSR_BIT_INTERNAL] = internal_change_flag_in; // [RL13]
    end

    sbsr_mask_reg u_mask (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .ce_in    (ce_in),
        .wr_in    (mask_wr_in),
        .wdata_in (mask_wdata_in),
        .mask_out (mask)
    );

    sbsr_summary u_summ (
        .status_in   (status),
        .mask_in     (mask),
        .summary_out (summary)
    );

    // ------------------------------------------------------------
    // request flag and read answers
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.summ_q = summary;
        st_nxt.rvalid = 1'b0;
        // a poll reports the flag and then clears it; a new rising edge
        // in the same cycle wins so no request is lost
        if (poll_in) begin
            st_nxt.rqs = 1'b0; // [RL15]
        end
        if (summary && !st_r.summ_q) begin
            st_nxt.rqs = 1'b1; // [RL15] [RL9]
        end
        // priority poll, status, mask when several arrive together
        if (poll_in) begin
            st_nxt.rdata = status;
            st_nxt.rdata[SBSR_BIT_SUMMARY] = st_r.rqs; // [RL7]
            st_nxt.rvalid = 1'b1;
        end else if (status_rd_in) begin
            st_nxt.rdata = status;
            st_nxt.rdata[SBSR_BIT_SUMMARY] = summary; // [RL6]
            st_nxt.rvalid = 1'b1;
        end else if (mask_rd_in) begin
            st_nxt.rdata = mask; // [RL4] [RL3]
            st_nxt.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out   = st_r.rdata;
    assign rvalid_out  = st_r.rvalid;
    assign srq_out     = st_r.rqs; // [RL9]
    assign summary_out = summary;  // [RL8]
endmodule // sbsr_top

// ### verification/sbsr_sva.sv
`timescale 1ns/1ps
module sbsr_sva (
    input wire logic       clock_in,
    input wire logic       nrst_in,
    input wire logic       ce_in,
    input wire logic       mask_rd_in,
    input wire logic       status_rd_in,
    input wire logic       poll_in,
    input wire logic [7:0] rdata_out,
    input wire logic       rvalid_out,
    input wire logic       srq_out,
    input wire logic       summary_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    wire req = ce_in && (mask_rd_in || status_rd_in || poll_in);
    wire mr  = ce_in && mask_rd_in && !status_rd_in && !poll_in;
    wire sr  = ce_in && status_rd_in && !poll_in;
    wire pl  = ce_in && poll_in;
    AST_ANSWER: assert property (req |=> rvalid_out) else $error("no answer");
    // with the enable low the answer register is frozen, so only enabled idle edges count
    AST_NO_ANSWER: assert property (ce_in && !req |=> !rvalid_out) else $error("stray answer");
    AST_MASK_TOP: assert property (mr |=> !rdata_out[6]) else $error("mask bit 6 set");
    AST_RSV: assert property (sr |=> (rdata_out & 8'h8a) == 8'h00) else $error("rsv set");
    AST_STB_SUM: assert property (sr |=> rdata_out[6] == $past(summary_out))
        else $error("status bit 6 wrong");
    AST_POLL_FLAG: assert property (pl |=> rdata_out[6] == $past(srq_out))
        else $error("poll bit 6 wrong");
    AST_SRQ_SET: assert property (ce_in && $past(ce_in) && $rose(summary_out) |=> srq_out)
        else $error("no request");
    AST_SRQ_HOLD: assert property (srq_out && !pl |=> srq_out) else $error("request lost");
endmodule // sbsr_sva
bind sbsr_top sbsr_sva u_sbsr_sva (.clock_in, .nrst_in, .ce_in, .mask_rd_in, .status_rd_in,
    .poll_in, .rdata_out, .rvalid_out, .srq_out, .summary_out);

// ### verification/sbsr_ctrl_model.sv
`timescale 1ns/1ps
module sbsr_ctrl_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output logic            wr_out,
    output logic      [7:0] wd_out,
    output logic            mrd_out,
    output logic            srd_out,
    output logic            poll_out
);
    initial {wr_out, wd_out, mrd_out, srd_out, poll_out} = 12'h000;
    // kind 0 write, 1 mask query, 2 status query, 3 poll; data bus inverted once released
    task automatic req(input int k, input logic [7:0] d, output logic [8:0] r);
        @(posedge clock_in);
        wr_out   <= k == 0;
        wd_out   <= d;
        mrd_out  <= k == 1;
        srd_out  <= k == 2;
        poll_out <= k == 3;
        @(posedge clock_in);
        {wr_out, mrd_out, srd_out, poll_out} <= 4'h0;
        wd_out <= ~d;
        @(negedge clock_in);
        r = {rvalid_in, rdata_in};
    endtask
endmodule // sbsr_ctrl_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    logic       clock_in = 0, nrst_in = 0, ce = 1'b1, srq, summary, rvalid, wr, rd, st, pl;
    logic [3:0] src = 4'h0;
    logic [7:0] rdata, wd;
    logic [8:0] r;
    int         errors = 0, num_checks = 0;
    sbsr_top u_sbsr_top (.clock_in, .nrst_in, .ce_in(ce), .event_summary_in(src[3]),
        .queue_not_empty_in(src[2]), .value_adapted_flag_in(src[1]),
        .internal_change_flag_in(src[0]), .mask_wr_in(wr), .mask_wdata_in(wd), .mask_rd_in(rd),
        .status_rd_in(st), .poll_in(pl), .rdata_out(rdata), .rvalid_out(rvalid),
        .srq_out(srq), .summary_out(summary));
    sbsr_ctrl_model u_sbsr_ctrl_model (.clock_in, .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_out(wr), .wd_out(wd), .mrd_out(rd), .srd_out(st), .poll_out(pl));
    initial forever #20 clock_in = ~clock_in;
    task automatic q(input int k, input logic [7:0] d);
        u_sbsr_ctrl_model.req(k, d, r);
    endtask
    task automatic t_mask();
        q(0, 8'hff);
        q(1, 8'h00);
        `CHK(r, 9'h1bf)
        q(0, 8'h11);
        q(1, 8'h00);
        `CHK(r, 9'h111)
        $display("mask test done");
    endtask
    task automatic t_status();
        q(0, 8'h00);
        @(posedge clock_in) src <= 4'hf;
        q(2, 8'h00);
        `CHK(r, 9'h135)
        `CHK(srq, 1'b0)
        `CHK(summary, 1'b0)
        $display("status test done");
    endtask
    task automatic t_block();
        // only reserved bits and bit 6 written (bit 6 reads back zero): nothing may reach the summary
        q(0, 8'hca);
        q(1, 8'h00);
        `CHK(r, 9'h18a)
        `CHK(summary, 1'b0)
        $display("block test done");
    endtask
    task automatic t_srq();
        // queue bit enabled: summary rises, request latched until polled
        q(0, 8'h10);
        q(3, 8'h00);
        `CHK(r, 9'h175)
        `CHK(srq, 1'b0)
        q(2, 8'h00);
        `CHK(r, 9'h175)
        `CHK(summary, 1'b1)
        $display("request test done");
    endtask
    task automatic t_freeze();
        // with the enable low a write is ignored and no answer appears
        @(posedge clock_in) ce <= 1'b0;
        q(0, 8'h01);
        `CHK(r[8], 1'b0)
        @(posedge clock_in) ce <= 1'b1;
        q(1, 8'h00);
        `CHK(r, 9'h110)
        $display("freeze test done");
    endtask
    task automatic t_reset();
        // raise the request again, let it stand, then reset in mid-run
        q(0, 8'h00);
        q(0, 8'h10);
        repeat (2) @(negedge clock_in);
        `CHK(srq, 1'b1)
        @(posedge clock_in) nrst_in <= 1'b0;
        @(posedge clock_in) nrst_in <= 1'b1;
        @(negedge clock_in);
        `CHK({srq, summary, rvalid, rdata}, 11'h000)
        q(1, 8'h00);
        `CHK(r, 9'h100)
        $display("reset test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_mask();
        t_status();
        t_block();
        t_srq();
        t_freeze();
        t_reset();
        give_verdict();
    end
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
endmodule // testbench
